// ==== hw/frde_fifo.sv ====
// data fifo with registered read stage
`timescale 1ns/1ps
module frde_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic rstn,
  frde_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic outValid;
    logic [WIDTH-1:0] outData;
  } frde_fifo_state_t;

  frde_fifo_state_t q, n;
  logic memEmpty;
  logic memFull;

  always_comb begin
    n = q;
    memEmpty = (q.wp == q.rp);
    memFull = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
    if (port.wrValid && !memFull) begin
      n.mem[q.wp[AW-1:0]] = port.wrData;
      n.wp = q.wp + 1'b1;
    end
    // output stage refills whenever it is free or being taken
    if (!q.outValid || port.rdReady) begin
      if (!memEmpty) begin
        n.outData = q.mem[q.rp[AW-1:0]];
        n.outValid = 1'b1;
        n.rp = q.rp + 1'b1;
      end else begin
        n.outValid = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign port.wrReady = !memFull;
  assign port.rdValid = q.outValid;
  assign port.rdData = q.outData;
  assign port.idle = memEmpty && !q.outValid;

  a_fifo_no_overfill: assert property (@(posedge mclk) disable iff (!rstn)
    memFull && !(!q.outValid || port.rdReady) |=> $stable(q.wp)) else $error("fifo overfilled");
endmodule

// ==== hw/frde_fifo_if.sv ====
// stream carrier between the engine and its data fifo
`timescale 1ns/1ps
interface frde_fifo_if #(parameter int WIDTH = 8);
  logic wrValid;
  logic [WIDTH-1:0] wrData;
  logic wrReady;
  logic rdValid;
  logic [WIDTH-1:0] rdData;
  logic rdReady;
  logic idle;
  modport fifo (input wrValid, wrData, rdReady, output wrReady, rdValid, rdData, idle);
  modport src (output wrValid, wrData, input wrReady, idle);
  modport snk (input rdValid, rdData, output rdReady);
endinterface

// ==== hw/frde_params.svh ====
// constants of the floppy read data engine
`ifndef FRDE_PARAMS_SVH
`define FRDE_PARAMS_SVH

`define FRDE_OP_READ 5'h06
`define FRDE_OP_READ_DEL 5'h0C
`define FRDE_OP_VERIFY 5'h16
`define FRDE_OP_LOCK 5'h14
`define FRDE_ST_INVALID 8'h80
`define FRDE_CMD_LAST 4'h8
`define FRDE_RES_LEN 3'h7
`define FRDE_RES_ONE 3'h1
`define FRDE_IC_ABN 2'h1
`define FRDE_SIZE_BASE 15'h0080
`define FRDE_DTL_SHORT 8'h80
`define FRDE_FIRST_SECTOR 8'h01
`define FRDE_FIFO_WIDTH 8
`define FRDE_FIFO_DEPTH 32

`define FRDE_B_MT 7
`define FRDE_B_SK 5
`define FRDE_ST0_SE 5
`define FRDE_ST1_EN 7
`define FRDE_ST1_DE 5
`define FRDE_ST1_OR 4
`define FRDE_ST1_ND 2
`define FRDE_ST2_CM 6
`define FRDE_ST2_DD 5

`define FRDE_P_DRV 1
`define FRDE_P_CYL 2
`define FRDE_P_HEAD 3
`define FRDE_P_SEC 4
`define FRDE_P_SIZE 5
`define FRDE_P_EOT 6
`define FRDE_P_DTL 8

`endif

// ==== hw/frde_pkg.sv ====
// types of the floppy read data engine
package frde_pkg;

  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_SEEK, S_HEAD, S_SETTLE, S_SEARCH, S_MARK, S_DATA, S_DRAIN, S_RESULT
  } frde_state_t;

  typedef struct packed {
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] sec;
  } frde_addr_t;

  typedef struct packed {
    frde_state_t st;
    logic cmdReady;
    logic [3:0] idx;
    logic [8:0][7:0] prm;
    logic [6:0][7:0] res;
    logic [2:0] resCnt;
    logic [2:0] resLen;
    logic resValid;
    logic [7:0] resByte;
    logic [7:0] st0;
    logic [7:0] st1;
    logic [7:0] st2;
    frde_addr_t cur;
    frde_addr_t rep;
    logic stopDeliver;
    logic markStop;
    logic skipSector;
    logic idxCnt;
    logic [14:0] byteCnt;
    logic seekReq;
    logic [7:0] seekCyl;
    logic headLoad;
    logic [3:0] busy;
    logic lock;
    logic lastWasFormat;
    logic [7:0] fmtSc;
    logic [7:0] prevParam;
    logic tcS1;
    logic tcS2;
    logic ixS1;
    logic ixS2;
    logic ixS3;
  } frde_core_t;

endpackage

// ==== hw/frde_timer.sv ====
// one-shot cycle timer for head settle and unload
`timescale 1ns/1ps
module frde_timer (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic start,
  input wire logic clear,
  input wire logic [15:0] load,
  output logic done
);
  typedef struct packed {
    logic [15:0] cnt;
    logic run;
    logic done;
  } frde_timer_state_t;

  frde_timer_state_t q, n;

  always_comb begin
    n = q;
    n.done = 1'b0;
    if (clear) begin
      n.run = 1'b0;
    end else if (start) begin
      n.cnt = load;
      n.run = 1'b1;
    end else if (q.run) begin
      if (q.cnt <= 16'h0001) begin
        n.run = 1'b0;
        n.done = 1'b1;
      end else begin
        n.cnt = q.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign done = q.done;
endmodule

// ==== hw/frde_top.sv ====
// read data engine: command decode, search, transfer and result phases
// Functional notes
// RQ1: unknown opcode does nothing, returns one result byte 80H.
// RQ2: reported earlier parameter is sector count after format, else end-of-track.
// RQ3: host keeps command drive bits matching drive select outputs; never drive pins.
// RQ4: read, deleted read and verify share parameters and results, differ in bits 0-4.
// RQ5: with implied seek enabled, seek to requested cylinder before transfer.
// RQ6: addressed drive busy bit is set during the seek.
// RQ7: failed seek reported via status zero and failing cylinder byte.
// RQ8: host writes exactly nine command bytes for a read.
// RQ9: load head, wait settle time, match ID, move data field to fifo.
// RQ10: after each sector advance sector number and read the next one.
// RQ11: terminal count or overrun stops delivery; sector finished and CRC checked.
// RQ12: sector size is 128 shifted left by the size code.
// RQ13: size zero with short length below 128 delivers only that many bytes.
// RQ14: nonzero size code means short length is ignored.
// RQ15: both-sides flag reads side 0 then side 1 of a cylinder.
// RQ16: head stays loaded for the unload interval after a command.
// RQ17: two index pulses without match give class 01 and missing-sector flag.
// RQ18: CRC fault gives class 01, fault flag, ID field CRC flag in status two.
// RQ19: deleted-mark handling per skip flag, control-mark flag set.
// RQ20: sector address advances automatically during transfer.
// RQ21: result address is sector+1, or sector 1 with cylinder/head change.
// RQ22: command, execution and result phases; all results read before next command.
`timescale 1ns/1ps
`include "frde_params.svh"
module frde_top
  import frde_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] cmdByte,
  input wire logic cmdValid,
  output logic cmdReady,
  output logic [7:0] resByte,
  output logic resValid,
  input wire logic resReady,
  output logic [7:0] hostData,
  output logic hostDataValid,
  input wire logic hostDataReady,
  input wire logic terminalCount,
  input wire logic revolutionMarkerN,
  input wire logic idValid,
  input wire logic [7:0] idCyl,
  input wire logic [7:0] idHead,
  input wire logic [7:0] idSector,
  input wire logic [7:0] idSize,
  input wire logic idCrcErr,
  input wire logic dataMarkValid,
  input wire logic dataMarkDeleted,
  input wire logic diskByteValid,
  input wire logic [7:0] diskByte,
  input wire logic dataEnd,
  input wire logic dataCrcErr,
  input wire logic impliedSeekEn,
  input wire logic [15:0] settleCycles,
  input wire logic [15:0] unloadCycles,
  input wire logic [7:0] presentCyl,
  input wire logic seekDone,
  input wire logic seekFail,
  input wire logic formatDone,
  input wire logic [7:0] formatSectorCount,
  output logic seekReq,
  output logic [7:0] seekCyl,
  output logic headLoad,
  output logic headSide,
  output logic [3:0] driveBusy,
  output logic [1:0] paramDrive,
  output logic [7:0] prevParam,
  output logic lockState
);
  frde_core_t q, n;
  logic fifoPush;
  logic [7:0] fifoData;
  logic settleGo;
  logic unloadGo;
  logic unloadClr;
  logic settleDone;
  logic unloadDone;
  logic doEnd;
  logic indexEdge;
  logic tcSync;
  logic isVerify;
  logic isDel;
  logic bothSides;
  logic skipDeleted;
  logic otherMark;

  frde_fifo_if #(.WIDTH(`FRDE_FIFO_WIDTH)) fif ();

  frde_fifo #(.WIDTH(`FRDE_FIFO_WIDTH), .DEPTH(`FRDE_FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .port(fif)
  );

  frde_timer u_settle (
    .mclk(mclk),
    .rstn(rstn),
    .start(settleGo),
    .clear(1'b0),
    .load(settleCycles),
    .done(settleDone)
  );

  frde_timer u_unload (
    .mclk(mclk),
    .rstn(rstn),
    .start(unloadGo),
    .clear(unloadClr),
    .load(unloadCycles),
    .done(unloadDone)
  );

  function automatic logic isXfer(input logic [4:0] op);
    return op == `FRDE_OP_READ || op == `FRDE_OP_READ_DEL || op == `FRDE_OP_VERIFY; // RQ4
  endfunction

  function automatic logic [14:0] sizeBytes(input logic [7:0] code);
    return `FRDE_SIZE_BASE << code[2:0]; // RQ12
  endfunction

  function automatic logic [14:0] xferLimit(input logic [7:0] code, input logic [7:0] short_sector_length);
    if (code == 8'h00 && short_sector_length < `FRDE_DTL_SHORT) begin
      return {7'h00, short_sector_length}; // RQ13
    end
    return sizeBytes(code); // RQ14
  endfunction

  function automatic logic canGoOn(input frde_addr_t a, input logic [7:0] last_sector_on_track, input logic mt);
    return (a.sec != last_sector_on_track) || (mt && !a.head[0]);
  endfunction

  function automatic frde_addr_t nextAddr(input frde_addr_t a, input logic [7:0] last_sector_on_track,
                                          input logic mt);
    frde_addr_t r;
    r = a;
    if (a.sec != last_sector_on_track) begin
      r.sec = a.sec + 8'h01; // RQ21
    end else begin
      r.sec = `FRDE_FIRST_SECTOR; // RQ21
      r.head = {a.head[7:1], a.head[0] ^ mt}; // RQ15
      if (!(mt && !a.head[0])) begin
        r.cyl = a.cyl + 8'h01; // RQ21
      end
    end
    return r;
  endfunction

  assign indexEdge = q.ixS3 && !q.ixS2;
  assign tcSync = q.tcS2;
  assign isVerify = (q.prm[0][4:0] == `FRDE_OP_VERIFY);
  assign isDel = (q.prm[0][4:0] == `FRDE_OP_READ_DEL);
  assign bothSides = q.prm[0][`FRDE_B_MT];
  assign skipDeleted = q.prm[0][`FRDE_B_SK];
  // the deleted-data command treats a normal mark as the odd one
  assign otherMark = dataMarkDeleted ^ isDel;

  always_comb begin
    n = q;
    fifoPush = 1'b0;
    fifoData = diskByte;
    settleGo = 1'b0;
    unloadGo = 1'b0;
    unloadClr = 1'b0;
    doEnd = 1'b0;
    // first stage feeds only the second
    n.tcS1 = terminalCount;
    n.tcS2 = q.tcS1;
    n.ixS1 = revolutionMarkerN;
    n.ixS2 = q.ixS1;
    n.ixS3 = q.ixS2;
    if (unloadDone) begin
      n.headLoad = 1'b0; // RQ16
    end
    if (formatDone) begin
      n.lastWasFormat = 1'b1;
      n.fmtSc = formatSectorCount;
      n.prevParam = formatSectorCount; // RQ2
    end
    case (q.st)
      S_IDLE: begin
        if (cmdValid && q.cmdReady) begin
          n.prm[0] = cmdByte;
          n.idx = 4'h1;
          if (isXfer(cmdByte[4:0])) begin
            n.st = S_CMD;
          end else if (cmdByte[6:0] == {2'h0, `FRDE_OP_LOCK}) begin
            n.lock = cmdByte[7];
            n.res[0] = {3'h0, cmdByte[7], 4'h0};
            n.resByte = {3'h0, cmdByte[7], 4'h0};
            n.resLen = `FRDE_RES_ONE;
            n.resCnt = 3'h0;
            n.resValid = 1'b1;
            n.cmdReady = 1'b0;
            n.st = S_RESULT;
          end else begin
            n.res[0] = `FRDE_ST_INVALID; // RQ1
            n.resByte = `FRDE_ST_INVALID; // RQ1
            n.resLen = `FRDE_RES_ONE;
            n.resCnt = 3'h0;
            n.resValid = 1'b1;
            n.cmdReady = 1'b0;
            n.st = S_RESULT;
          end
        end
      end
      S_CMD: begin
        if (cmdValid) begin
          n.prm[q.idx] = cmdByte;
          n.idx = q.idx + 4'h1;
          if (q.idx == `FRDE_CMD_LAST) begin // RQ8
            n.cmdReady = 1'b0;
            n.cur = {q.prm[`FRDE_P_CYL], q.prm[`FRDE_P_HEAD], q.prm[`FRDE_P_SEC]};
            n.rep = n.cur;
            n.st0 = {5'h00, q.prm[`FRDE_P_DRV][2:0]};
            n.st1 = 8'h00;
            n.st2 = 8'h00;
            n.stopDeliver = 1'b0;
            n.markStop = 1'b0;
            n.lastWasFormat = formatDone;
            n.prevParam = formatDone ? formatSectorCount : q.prm[`FRDE_P_EOT]; // RQ2
            if (impliedSeekEn && q.prm[`FRDE_P_CYL] != presentCyl) begin
              n.seekReq = 1'b1; // RQ5
              n.seekCyl = q.prm[`FRDE_P_CYL];
              n.busy[q.prm[`FRDE_P_DRV][1:0]] = 1'b1; // RQ6
              n.st = S_SEEK;
            end else begin
              n.st = S_HEAD;
            end
          end
        end
      end
      S_SEEK: begin
        if (seekFail) begin
          n.st0[7:6] = `FRDE_IC_ABN; // RQ7
          n.st0[`FRDE_ST0_SE] = 1'b1;
          n.rep.cyl = presentCyl; // RQ7
          doEnd = 1'b1;
        end else if (seekDone) begin
          n.st = S_HEAD;
        end
        if (seekFail || seekDone) begin
          n.seekReq = 1'b0;
          n.busy = 4'h0;
        end
      end
      S_HEAD: begin
        unloadClr = 1'b1;
        n.idxCnt = 1'b0;
        if (q.headLoad && !unloadDone) begin
          n.st = S_SEARCH; // RQ16
        end else begin
          n.headLoad = 1'b1; // RQ9
          settleGo = 1'b1;
          n.st = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (settleDone) begin
          n.st = S_SEARCH; // RQ9
        end
      end
      S_SEARCH, S_MARK: begin
        if (indexEdge) begin
          n.idxCnt = 1'b1;
          if (q.idxCnt) begin
            n.st0[7:6] = `FRDE_IC_ABN; // RQ17
            n.st1[`FRDE_ST1_ND] = 1'b1; // RQ17
            doEnd = 1'b1;
          end else begin
            n.st = S_SEARCH;
          end
        end else if (q.st == S_SEARCH && idValid) begin
          if (idCrcErr) begin
            n.st0[7:6] = `FRDE_IC_ABN; // RQ18
            n.st1[`FRDE_ST1_DE] = 1'b1; // RQ18
            n.st2[`FRDE_ST2_DD] = 1'b1; // RQ18
            doEnd = 1'b1;
          end else if ({idCyl, idHead, idSector} == q.cur && idSize == q.prm[`FRDE_P_SIZE]) begin
            n.st = S_MARK; // RQ9
          end
        end else if (q.st == S_MARK && dataMarkValid) begin
          n.byteCnt = 15'h0000;
          n.skipSector = 1'b0;
          if (otherMark) begin
            n.st2[`FRDE_ST2_CM] = 1'b1; // RQ19
            if (skipDeleted) begin
              n.skipSector = 1'b1; // RQ19
            end else begin
              n.markStop = 1'b1; // RQ19
            end
          end
          n.st = S_DATA;
        end
      end
      S_DATA: begin
        if (diskByteValid) begin
          n.byteCnt = q.byteCnt + 15'h0001;
          if (!q.stopDeliver && !q.skipSector && !isVerify &&
              q.byteCnt < xferLimit(q.prm[`FRDE_P_SIZE], q.prm[`FRDE_P_DTL])) begin // RQ13
            if (fif.wrReady) begin
              fifoPush = 1'b1; // RQ9
            end else begin
              // overrun acts as an implied terminal count
              n.st1[`FRDE_ST1_OR] = 1'b1; // RQ11
              n.st0[7:6] = `FRDE_IC_ABN;
              n.stopDeliver = 1'b1; // RQ11
            end
          end
        end
        if (tcSync) begin
          n.stopDeliver = 1'b1; // RQ11
        end
        if (dataEnd) begin
          if (dataCrcErr) begin
            n.st0[7:6] = `FRDE_IC_ABN; // RQ18
            n.st1[`FRDE_ST1_DE] = 1'b1; // RQ18
            n.rep = q.cur;
            doEnd = 1'b1;
          end else if (n.stopDeliver) begin
            n.rep = nextAddr(q.cur, q.prm[`FRDE_P_EOT], bothSides); // RQ11
            doEnd = 1'b1;
          end else if (q.markStop) begin
            n.rep = q.cur; // RQ19
            doEnd = 1'b1;
          end else if (canGoOn(q.cur, q.prm[`FRDE_P_EOT], bothSides)) begin
            n.cur = nextAddr(q.cur, q.prm[`FRDE_P_EOT], bothSides); // RQ10 RQ20
            n.idxCnt = 1'b0;
            n.st = S_SEARCH; // RQ10
          end else begin
            // ran off the cylinder without a terminal count
            n.st0[7:6] = `FRDE_IC_ABN;
            n.st1[`FRDE_ST1_EN] = 1'b1;
            n.rep = nextAddr(q.cur, q.prm[`FRDE_P_EOT], bothSides); // RQ21
            doEnd = 1'b1;
          end
        end
      end
      S_DRAIN: begin
        // results wait until the host has taken all data
        if (fif.idle) begin
          n.st = S_RESULT; // RQ22
          n.resValid = 1'b1;
          n.resCnt = 3'h0;
          n.resByte = q.res[0];
        end
      end
      S_RESULT: begin
        if (q.resValid && resReady) begin
          if (q.resCnt == q.resLen - 3'h1) begin
            n.resValid = 1'b0;
            n.cmdReady = 1'b1; // RQ22
            n.st = S_IDLE;
          end else begin
            n.resCnt = q.resCnt + 3'h1;
            n.resByte = q.res[q.resCnt + 3'h1];
          end
        end
      end
      default: begin
        n.st = S_IDLE;
        n.cmdReady = 1'b1;
      end
    endcase
    if (doEnd) begin
      n.res = {q.prm[`FRDE_P_SIZE], n.rep.sec, n.rep.head, n.rep.cyl, n.st2, n.st1, n.st0};
      n.resLen = `FRDE_RES_LEN; // RQ4
      n.st = S_DRAIN; // RQ22
      unloadGo = 1'b1; // RQ16
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.cmdReady <= 1'b1;
      q.st <= S_IDLE;
      q.ixS1 <= 1'b1;
      q.ixS2 <= 1'b1;
      q.ixS3 <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign fif.wrValid = fifoPush;
  assign fif.wrData = fifoData;
  assign fif.rdReady = hostDataReady;
  assign hostData = fif.rdData;
  assign hostDataValid = fif.rdValid;
  assign cmdReady = q.cmdReady;
  assign resByte = q.resByte;
  assign resValid = q.resValid;
  assign seekReq = q.seekReq;
  assign seekCyl = q.seekCyl;
  assign headLoad = q.headLoad;
  assign headSide = q.cur.head[0];
  assign driveBusy = q.busy;
  // internal copy only, never steers the select pins
  assign paramDrive = q.prm[`FRDE_P_DRV][1:0]; // RQ3
  assign prevParam = q.prevParam;
  assign lockState = q.lock;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_invalid_op_80: assert property (q.st == S_IDLE && cmdValid && !isXfer(cmdByte[4:0]) && // RQ1
    cmdByte[6:0] != {2'h0, `FRDE_OP_LOCK} |=> resValid && resByte == 8'h80 && !cmdReady)
    else $error("invalid opcode result wrong");
  a_lock_result: assert property (q.st == S_IDLE && cmdValid && cmdByte[6:0] == 7'h14 |=>
    resByte == {3'h0, $past(cmdByte[7]), 4'h0} && lockState == $past(cmdByte[7]))
    else $error("lock result wrong");
  a_seek_first: assert property (q.st == S_CMD && cmdValid && q.idx == 4'h8 && impliedSeekEn &&
    q.prm[2] != presentCyl |=> seekReq && seekCyl == $past(q.prm[2])) else $error("no seek"); // RQ5
  a_seek_busy: assert property (seekReq |-> driveBusy[paramDrive]) else $error("busy low"); // RQ6
  a_settle_hold: assert property (q.st == S_SETTLE && !settleDone |=> q.st == S_SETTLE && headLoad)
    else $error("settle skipped"); // RQ9
  a_two_index: assert property (q.st == S_SEARCH && indexEdge && q.idxCnt |=>
    q.st == S_DRAIN && q.st1[2] && q.st0[7:6] == 2'h1) else $error("missing sector"); // RQ17
  a_id_crc: assert property (q.st == S_SEARCH && !indexEdge && idValid && idCrcErr |=>
    q.st0[7:6] == 2'h1 && q.st1[5] && q.st2[5]) else $error("id crc status wrong"); // RQ18
  a_stop_deliver: assert property (q.stopDeliver |-> !fifoPush) else $error("data after stop"); // RQ11
  a_short_len: assert property (fifoPush |-> q.byteCnt <
    xferLimit(q.prm[5], q.prm[8])) else $error("too many bytes"); // RQ13
  a_result_hold: assert property (resValid && !resReady |=> resValid && $stable(resByte))
    else $error("result byte dropped"); // RQ22
  a_no_cmd_busy: assert property (q.st != S_IDLE && q.st != S_CMD |-> !cmdReady)
    else $error("command taken mid-operation"); // RQ22

  c_read_done: cover property (q.st == S_DRAIN ##[1:300] q.st == S_RESULT);
  c_overrun: cover property (q.st == S_DATA && diskByteValid && !fif.wrReady && !q.stopDeliver);
  c_side_switch: cover property (q.st == S_DATA && dataEnd && q.cur.sec == q.prm[6] && bothSides);
  c_lock_cmd: cover property (q.st == S_IDLE && cmdValid && cmdByte[6:0] == 7'h14);
endmodule

// ==== sim/floppy_read_data_engine_tb_top.sv ====
// bench of the read data engine against the drive model
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin failures++; \
  $display("FAIL %s expected %0h seen %0h", what, exp, got); end end
module floppy_read_data_engine_tb_top;
  logic mclk = 0, rstn = 0, cmdValid = 0, resReady = 0, hostDataReady = 1, terminalCount = 0;
  logic impliedSeekEn = 0, noMatch = 0, formatDone = 0, crcBad = 0, idBad = 0;
  logic [7:0] cmdByte = 0, presentCyl = 8'h05, trackCyl = 8'h05, lastSec = 8'h03;
  logic [7:0] delSec = 0, formatSc = 0, lastData;
  logic [15:0] unloadCycles = 16'h00C8;
  logic cmdReady, resValid, hostDataValid, seekReq, headLoad, headSide, lockState, seekDone;
  logic revolutionMarkerN, idValid, dataMarkValid, dataMarkDeleted, diskByteValid, dataEnd;
  logic [7:0] resByte, hostData, seekCyl, prevParam, idCyl, idHead, idSector, diskByte;
  logic [3:0] driveBusy;
  logic [7:0] res [7];
  logic [15:0] rows [5] = '{16'h0180, 16'h0580, 16'h1F80, 16'h9410, 16'h1400};
  int failures = 0, checks_done = 0, got = 0, waited = 0;
  frde_top dut (.mclk(mclk), .rstn(rstn), .cmdByte(cmdByte), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .resByte(resByte), .resValid(resValid), .resReady(resReady),
    .hostData(hostData), .hostDataValid(hostDataValid), .hostDataReady(hostDataReady),
    .terminalCount(terminalCount), .revolutionMarkerN(revolutionMarkerN), .idValid(idValid),
    .idCyl(idCyl), .idHead(idHead), .idSector(idSector), .idSize(8'h00), .idCrcErr(idBad),
    .dataMarkValid(dataMarkValid), .dataMarkDeleted(dataMarkDeleted),
    .diskByteValid(diskByteValid), .diskByte(diskByte), .dataEnd(dataEnd), .dataCrcErr(crcBad),
    .impliedSeekEn(impliedSeekEn), .settleCycles(16'h0004), .unloadCycles(unloadCycles),
    .presentCyl(presentCyl), .seekDone(seekDone), .seekFail(1'b0), .formatDone(formatDone),
    .formatSectorCount(formatSc), .seekReq(seekReq), .seekCyl(seekCyl), .headLoad(headLoad),
    .headSide(headSide), .driveBusy(driveBusy), .paramDrive(), .prevParam(prevParam),
    .lockState(lockState));
  frde_disk_model drive (.mclk(mclk), .headLoad(headLoad), .headSide(headSide),
    .seekReq(seekReq), .trackCyl(trackCyl), .lastSec(lastSec), .delSec(delSec),
    .noMatch(noMatch), .revolutionMarkerN(revolutionMarkerN), .idValid(idValid),
    .idCyl(idCyl), .idHead(idHead), .idSector(idSector), .dataMarkValid(dataMarkValid),
    .dataMarkDeleted(dataMarkDeleted), .diskByteValid(diskByteValid), .diskByte(diskByte),
    .dataEnd(dataEnd), .seekDone(seekDone));
  always #10 mclk = ~mclk;
  always @(posedge mclk) if (hostDataValid && hostDataReady)
    {got, lastData} <= {got + 1, hostData};
  task automatic step;
    waited++;
    if (waited > 30000) begin
      failures++;
      give_verdict();
    end
    @(posedge mclk);
    #2;
  endtask
  task automatic send(input logic [7:0] b);
    waited = 0;
    cmdByte = b;
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1) step();
    step();
  endtask
  task automatic getRes(input int k);
    waited = 0;
    resReady = 1'b1;
    for (int i = 0; i < k; i++) begin
      while (resValid !== 1'b1) step();
      res[i] = resByte;
      step();
    end
    resReady = 1'b0;
  endtask
  task automatic xfer(input string name, input logic [7:0] op, c, last_sector_on_track, short_sector_length,
      input logic [55:0] exp, input int nb);
    logic [71:0] cb;
    got = 0;
    cb = {op, 8'h00, c, 8'h00, 8'h01, 8'h00, last_sector_on_track, 8'h1B, short_sector_length};
    for (int i = 8; i >= 0; i--) send(cb[8*i +: 8]);
    cmdValid = 1'b0;
    getRes(7);
    for (int i = 0; i < 7; i++) `CHK("result byte", exp[55-8*i -: 8], res[i])
    if (nb >= 0) `CHK("data bytes", nb, got)
    $display("test %s done", name);
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #30 `CHK("ready in reset", 1'b1, cmdReady)
    `CHK("quiet in reset", 1'b0, resValid | seekReq | headLoad)
    repeat (2) @(posedge mclk);
    #2 rstn = 1'b1;
    foreach (rows[i]) begin
      send(rows[i][15:8]);
      cmdValid = 1'b0;
      getRes(1);
      `CHK("short result", rows[i][7:0], res[0])
      if (rows[i][12:8] == 5'h14) `CHK("lock", rows[i][4], lockState)
      $display("test opcode %0h done", rows[i][15:8]);
    end
    formatSc = 8'h12;
    formatDone = 1'b1;
    step();
    formatDone = 1'b0;
    step();
    `CHK("earlier param", 8'h12, prevParam)
    xfer("multi sector", 8'h06, 8'h05, 8'h02, 8'hFF, 56'h40800006000100, 256);
    `CHK("earlier param", 8'h02, prevParam)
    `CHK("head held", 1'b1, headLoad)
    xfer("short length", 8'h06, 8'h05, 8'h01, 8'h10, 56'h40800006000100, 16);
    `CHK("last byte", 8'h0E, lastData)
    xfer("both sides", 8'h86, 8'h05, 8'h02, 8'hFF, 56'h40800006000100, 512);
    xfer("verify", 8'h16, 8'h05, 8'h01, 8'hFF, 56'h40800006000100, 0);
    delSec = 8'h01;
    xfer("deleted read", 8'h06, 8'h05, 8'h02, 8'hFF, 56'h00004005000100, 128);
    xfer("deleted skip", 8'h26, 8'h05, 8'h02, 8'hFF, 56'h40804006000100, 128);
    delSec = 8'h00;
    noMatch = 1'b1;
    xfer("missing", 8'h06, 8'h05, 8'h02, 8'hFF, 56'h40040005000100, 0);
    noMatch = 1'b0;
    crcBad = 1'b1;
    xfer("data crc", 8'h06, 8'h05, 8'h01, 8'hFF, 56'h40200005000100, 128);
    crcBad = 1'b0;
    idBad = 1'b1;
    xfer("id crc", 8'h06, 8'h05, 8'h01, 8'hFF, 56'h40202005000100, 0);
    idBad = 1'b0;
    impliedSeekEn = 1'b1;
    presentCyl = 8'h03;
    fork
      xfer("implied seek", 8'h06, 8'h05, 8'h01, 8'hFF, 56'h40800006000100, 128);
      begin
        for (int k = 0; k < 500 && seekReq !== 1'b1; k++) @(posedge mclk) #2;
        `CHK("seek cylinder", 8'h05, seekCyl)
        `CHK("drive busy", 4'h1, driveBusy)
      end
    join
    impliedSeekEn = 1'b0;
    fork
      xfer("terminal count", 8'h06, 8'h05, 8'h03, 8'hFF, 56'h00000005000200, -1);
      begin
        for (int k = 0; k < 5000 && got < 10; k++) @(posedge mclk) #2;
        terminalCount = 1'b1;
      end
    join
    `CHK("delivery stopped", 1'b1, got < 128)
    terminalCount = 1'b0;
    give_verdict();
  end
endmodule

// ==== sim/frde_disk_model.sv ====
// drive side model: spinning track with index mark, seek responder
`timescale 1ns/1ps
module frde_disk_model (
  input wire logic mclk,
  input wire logic headLoad,
  input wire logic headSide,
  input wire logic seekReq,
  input wire logic [7:0] trackCyl,
  input wire logic [7:0] lastSec,
  input wire logic [7:0] delSec,
  input wire logic noMatch,
  output logic revolutionMarkerN,
  output logic idValid,
  output logic [7:0] idCyl,
  output logic [7:0] idHead,
  output logic [7:0] idSector,
  output logic dataMarkValid,
  output logic dataMarkDeleted,
  output logic diskByteValid,
  output logic [7:0] diskByte,
  output logic dataEnd,
  output logic seekDone
);
  task automatic edge2;
    @(posedge mclk);
    #2;
  endtask
  initial begin
    {idValid, dataMarkValid, dataMarkDeleted, diskByteValid, dataEnd, seekDone} = '0;
    {idCyl, idHead, idSector, diskByte} = '0;
    revolutionMarkerN = 1'b1;
    forever begin
      // each revolution only starts under a loaded head
      @(posedge mclk iff headLoad);
      #2 revolutionMarkerN = 1'b0;
      edge2();
      revolutionMarkerN = 1'b1;
      for (int r = 1; r <= lastSec; r++) begin
        repeat (4) edge2();
        {idValid, idCyl, idHead} = {1'b1, trackCyl, 7'h00, headSide};
        idSector = noMatch ? 8'hEE : 8'(r);
        edge2();
        idValid = 1'b0;
        // stale fields flip so nothing leans on old values
        {idCyl, idHead, idSector} = ~{idCyl, idHead, idSector};
        repeat (2) edge2();
        {dataMarkValid, dataMarkDeleted} = {1'b1, 8'(r) == delSec};
        edge2();
        dataMarkValid = 1'b0;
        for (int i = 0; i < 128; i++) begin
          {diskByteValid, diskByte} = {1'b1, 8'(i) ^ 8'(r)};
          edge2();
          diskByteValid = 1'b0;
          diskByte = ~diskByte;
          edge2();
        end
        dataEnd = 1'b1;
        edge2();
        dataEnd = 1'b0;
      end
    end
  end
  always begin
    @(posedge mclk iff seekReq);
    repeat (3) edge2();
    seekDone = 1'b1;
    edge2();
    seekDone = 1'b0;
  end
endmodule
